// ### logic/dbpp_pkg.sv
// Package: constants, register map and types for the byte-port packing channel.
// Assumes a single clk_sys domain at 200 MHz and a plain register port.
package dbpp_pkg;
  localparam int DBPP_AW = 4;
  localparam logic [3:0] DBPP_OFS_CTRL = 4'h0;
  localparam logic [3:0] DBPP_OFS_COUNT = 4'h1;
  localparam logic [3:0] DBPP_OFS_ADDR = 4'h2;
  localparam logic [3:0] DBPP_OFS_STATUS = 4'h3;
  localparam logic [3:0] DBPP_OFS_IRQ_STAT = 4'h4;
  localparam logic [3:0] DBPP_OFS_IRQ_EN = 4'h5;
  localparam logic [3:0] DBPP_OFS_IRQ_CLR = 4'h6;
  // Control register fields
  localparam int DBPP_CTRL_START = 0;
  localparam int DBPP_CTRL_SAB = 1;
  localparam int DBPP_CTRL_DUAL = 2;
  localparam int DBPP_CTRL_P2M = 3;
  localparam int DBPP_CTRL_EXTREQ = 4;
  localparam int DBPP_CTRL_PORT8 = 5;
  localparam int DBPP_CTRL_ABTMODE = 6;
  localparam int DBPP_CTRL_BURST = 7;
  localparam int DBPP_CTRL_SIZE_LO = 8;
  localparam int DBPP_CTRL_W = 10;
  localparam logic [1:0] DBPP_SIZE_BYTE = 2'h0;
  localparam logic [1:0] DBPP_SIZE_WORD = 2'h1;
  localparam logic [1:0] DBPP_SIZE_BPB = 2'h3;
  // Interrupt / status bits
  localparam int DBPP_EV_DONE = 0;
  localparam int DBPP_EV_ABORT = 1;
  localparam int DBPP_EV_CFGERR = 2;
  localparam int DBPP_EV_W = 3;
  localparam logic [31:0] DBPP_ZERO32 = 32'h0000_0000;
  typedef enum logic [2:0] {
    DBPP_IDLE,
    DBPP_BUSREQ,
    DBPP_RD_BYTE,
    DBPP_WR_MEM
  } dbpp_state_t;
endpackage

// ### logic/dbpp_mem_if.sv
// Interface: memory-side write path between the channel core and its bus master.
// Assumes both ends on clk_sys.
`timescale 1ns/1ps
interface dbpp_mem_if;
  logic wr_req;
  logic [31:0] wr_addr;
  logic [15:0] wr_data;
  logic [1:0] wr_be;
  logic wr_done;
  modport core (output wr_req, output wr_addr, output wr_data, output wr_be, input wr_done);
  modport master (input wr_req, input wr_addr, input wr_data, input wr_be, output wr_done);
endinterface

// ### logic/dbpp_sync2.sv
// Two-flop synchroniser for pin inputs.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/1ps
module dbpp_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ### logic/dbpp_mem_wr.sv
// Memory write master: drives one memory write per request, one cycle.
// Assumes memory accepts a write in the cycle it is presented.
`timescale 1ns/1ps
module dbpp_mem_wr
  import dbpp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  dbpp_mem_if.master mif,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic [1:0] mem_be
);
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      mem_we <= 1'b0;
      mem_addr <= DBPP_ZERO32;
      mem_wdata <= 16'h0000;
      mem_be <= 2'h0;
    end
    else
    begin
      mem_we <= mif.wr_req;
      mem_addr <= mif.wr_addr;
      mem_wdata <= mif.wr_data;
      mem_be <= mif.wr_be;
    end
  end
  assign mif.wr_done = mif.wr_req;
endmodule

// ### logic/dbpp_channel.sv
// Byte-port packing DMA channel: peripheral byte reads, packed or single memory writes.
// Assumes clk_sys 200 MHz, synchronous sys_rst, pins from outside synchronised here.
// Operation
// - Dual, 8-bit port, ext request, P->M, size 01: read byte, read byte, write word.
// - Stop after first byte leaves it in the holding register; a restarted packed run writes it as the first word's high byte.
// - Holding register has no processor read or write path.
// - Single addressing never strands a byte on early termination.
// - Size 11 under same conditions: byte read then byte write, repeat.
// - Variant without byte mode flags size 11 as configuration error if the control register already holds size 11 when start is written.
// - Chip select while requesting bus withdraws the bus request.
// - Burst mode performs exactly count transfers, no extra one.
`timescale 1ns/1ps
module dbpp_channel
  import dbpp_pkg::*;
#(
  parameter bit HAS_BYTE_MODE = 1'b1,
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [DBPP_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic cpu_cs,
  input wire logic ext_req,
  input wire logic peripheral_control_line,
  input wire logic bus_grant_acknowledge,
  output logic bus_request_out,
  output logic per_rd,
  input wire logic [7:0] per_data,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic [1:0] mem_be,
  output logic irq
);
  dbpp_mem_if mif ();
  logic [DBPP_CTRL_W-1:0] ctrl_reg;
  logic [CNT_W-1:0] count_reg;
  logic [31:0] addr_reg;
  logic [DBPP_EV_W-1:0] ev_stat_reg;
  logic [DBPP_EV_W-1:0] ev_en_reg;
  logic [7:0] hold_reg;
  logic [7:0] low_reg;
  logic hold_full_reg;
  logic busy_reg;
  logic br_reg;
  dbpp_state_t state_reg;
  logic cs_s;
  logic req_s;
  logic pcl_s;
  logic bus_grant_acknowledge_s;
  logic [DBPP_EV_W-1:0] ev_set;
  logic start_wr;
  logic [1:0] size_f;
  logic cfg_err;
  logic packing;
  logic abort_now;
  logic stop_early;

  dbpp_sync2 #(.W(4)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d({cpu_cs, ext_req, peripheral_control_line, bus_grant_acknowledge}),
    .q({cs_s, req_s, pcl_s, bus_grant_acknowledge_s})
  );

  dbpp_mem_wr u_wr (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .mif(mif),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_be(mem_be)
  );

  function automatic logic is_wr(input logic [DBPP_AW-1:0] a, input logic [DBPP_AW-1:0] o);
    is_wr = (a == o);
  endfunction

  assign size_f = ctrl_reg[DBPP_CTRL_SIZE_LO +: 2];
  assign start_wr = reg_wr && is_wr(reg_addr, DBPP_OFS_CTRL) && reg_wdata[DBPP_CTRL_START];
  assign cfg_err = (size_f == DBPP_SIZE_BPB) && !HAS_BYTE_MODE;
  // Packing applies only with dual addressing, 8-bit port, ext request, P->M
  assign packing = ctrl_reg[DBPP_CTRL_DUAL] && ctrl_reg[DBPP_CTRL_PORT8]
                && ctrl_reg[DBPP_CTRL_EXTREQ] && ctrl_reg[DBPP_CTRL_P2M]
                && (size_f == DBPP_SIZE_WORD);
  assign abort_now = ctrl_reg[DBPP_CTRL_SAB]
                  || (ctrl_reg[DBPP_CTRL_ABTMODE] && pcl_s);
  assign stop_early = busy_reg && abort_now && (count_reg != '0);

  // Control register; start self-clears, abort bit stays until written
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ctrl_reg <= '0;
    else if (reg_wr && is_wr(reg_addr, DBPP_OFS_CTRL))
      ctrl_reg <= reg_wdata[DBPP_CTRL_W-1:0] & ~(DBPP_CTRL_W'(1) << DBPP_CTRL_START);
  end

  // Channel sequencer
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_reg <= DBPP_IDLE;
      busy_reg <= 1'b0;
      count_reg <= '0;
      addr_reg <= DBPP_ZERO32;
      hold_reg <= 8'h00;
      low_reg <= 8'h00;
      hold_full_reg <= 1'b0;
      per_rd <= 1'b0;
    end
    else
    begin
      per_rd <= 1'b0;
      if (reg_wr && is_wr(reg_addr, DBPP_OFS_COUNT) && !busy_reg)
        count_reg <= reg_wdata[CNT_W-1:0];
      if (reg_wr && is_wr(reg_addr, DBPP_OFS_ADDR) && !busy_reg)
        addr_reg <= reg_wdata;
      case (state_reg)
        DBPP_IDLE:
        begin
          if (start_wr && !cfg_err && (count_reg != '0))
          begin
            busy_reg <= 1'b1;
            state_reg <= DBPP_BUSREQ;
          end
        end
        DBPP_BUSREQ:
        begin
          if (stop_early)
          begin
            // Half-packed byte stays put: software has no path to it
            busy_reg <= 1'b0;
            state_reg <= DBPP_IDLE;
          end
          else if (bus_grant_acknowledge_s && req_s)
            state_reg <= DBPP_RD_BYTE;
        end
        DBPP_RD_BYTE:
        begin
          per_rd <= 1'b1;
          // Second packed byte must not overwrite the first one still held
          if (packing && hold_full_reg)
            low_reg <= per_data;
          else
            hold_reg <= per_data;
          if (packing && !hold_full_reg)
          begin
            hold_full_reg <= 1'b1;
            state_reg <= DBPP_BUSREQ;
          end
          else
            state_reg <= DBPP_WR_MEM;
        end
        DBPP_WR_MEM:
        begin
          hold_full_reg <= 1'b0;
          addr_reg <= addr_reg + (packing ? 32'h0000_0002 : 32'h0000_0001);
          count_reg <= count_reg - 1'b1;
          if (count_reg == CNT_W'(1))
          begin
            busy_reg <= 1'b0;
            state_reg <= DBPP_IDLE;
          end
          else
            state_reg <= DBPP_BUSREQ;
        end
        default:
          state_reg <= DBPP_IDLE;
      endcase
    end
  end

  // Memory write: packed word in packing mode, single byte otherwise
  always_comb
  begin
    mif.wr_req = (state_reg == DBPP_WR_MEM);
    mif.wr_addr = addr_reg;
    mif.wr_data = packing ? {hold_reg, low_reg} : {8'h00, hold_reg};
    mif.wr_be = packing ? 2'h3 : 2'h1;
  end

  // Bus request: held until acknowledge, dropped on chip select
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      br_reg <= 1'b0;
    else if (cs_s && !bus_grant_acknowledge_s)
      br_reg <= 1'b0;
    else if (state_reg == DBPP_BUSREQ && !stop_early)
      br_reg <= 1'b1;
    else if (bus_grant_acknowledge_s || state_reg == DBPP_IDLE)
      br_reg <= 1'b0;
  end
  assign bus_request_out = br_reg;

  // Events: set wins over clear
  always_comb
  begin
    ev_set = '0;
    ev_set[DBPP_EV_DONE] = (state_reg == DBPP_WR_MEM) && (count_reg == CNT_W'(1));
    ev_set[DBPP_EV_ABORT] = (state_reg == DBPP_BUSREQ) && stop_early;
    ev_set[DBPP_EV_CFGERR] = start_wr && cfg_err && (state_reg == DBPP_IDLE);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ev_stat_reg <= '0;
    else if (reg_wr && is_wr(reg_addr, DBPP_OFS_IRQ_CLR))
      ev_stat_reg <= (ev_stat_reg & ~reg_wdata[DBPP_EV_W-1:0]) | ev_set;
    else
      ev_stat_reg <= ev_stat_reg | ev_set;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ev_en_reg <= '0;
    else if (reg_wr && is_wr(reg_addr, DBPP_OFS_IRQ_EN))
      ev_en_reg <= reg_wdata[DBPP_EV_W-1:0];
  end
  assign irq = |(ev_stat_reg & ev_en_reg);

  // Read port; holding register deliberately absent from the map
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= DBPP_ZERO32;
    else if (reg_rd)
    begin
      case (reg_addr)
        DBPP_OFS_CTRL: reg_rdata <= 32'(ctrl_reg);
        DBPP_OFS_COUNT: reg_rdata <= 32'(count_reg);
        DBPP_OFS_ADDR: reg_rdata <= addr_reg;
        DBPP_OFS_STATUS: reg_rdata <= {29'h0000_0000, hold_full_reg, br_reg, busy_reg};
        DBPP_OFS_IRQ_STAT: reg_rdata <= 32'(ev_stat_reg);
        DBPP_OFS_IRQ_EN: reg_rdata <= 32'(ev_en_reg);
        default: reg_rdata <= DBPP_ZERO32;
      endcase
    end
    else
      reg_rdata <= DBPP_ZERO32;
  end

  sequence s_two_reads;
    state_reg == DBPP_RD_BYTE ##[1:20] state_reg == DBPP_RD_BYTE;
  endsequence

  a_pack_two_reads: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (packing && state_reg == DBPP_WR_MEM) |-> $past(hold_full_reg))
    else $error("packed write without first byte held");
  a_pack_sequence: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (packing && state_reg == DBPP_RD_BYTE && !hold_full_reg) |=> state_reg == DBPP_BUSREQ)
    else $error("first packed byte not followed by second read");
  a_stranded_keep: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == DBPP_BUSREQ && stop_early && hold_full_reg) |=> !mif.wr_req && hold_full_reg)
    else $error("stranded byte was written or dropped");
  a_bpb_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (size_f == DBPP_SIZE_BPB && state_reg == DBPP_RD_BYTE) |=> state_reg == DBPP_WR_MEM)
    else $error("byte mode read not followed by write");
  a_cfg_error: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (start_wr && cfg_err && state_reg == DBPP_IDLE) |=> state_reg == DBPP_IDLE
      && ev_stat_reg[DBPP_EV_CFGERR])
    else $error("invalid size did not flag error");
  a_cs_drops_br: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cs_s && !bus_grant_acknowledge_s) |=> !bus_request_out)
    else $error("bus request not withdrawn on chip select");
  a_burst_exact: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_reg == DBPP_WR_MEM && count_reg == CNT_W'(1)) |=> state_reg == DBPP_IDLE && !busy_reg)
    else $error("extra transfer after count exhausted");
  a_br_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (bus_request_out && !bus_grant_acknowledge_s && !cs_s && state_reg == DBPP_BUSREQ && !stop_early)
      |=> bus_request_out)
    else $error("bus request dropped before acknowledge");
  a_abort_stops: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (stop_early && state_reg == DBPP_BUSREQ) |=> !busy_reg ##1 !mif.wr_req)
    else $error("abort did not stop channel");
endmodule

// ### dv/dbpp_far_side.sv
// Far-side model: bus arbiter granting after a set delay, and an 8-bit request peripheral.
// Assumes the channel samples per_data while reading and pulses per_rd once per byte.
`timescale 1ns/1ps
module dbpp_far_side (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic bus_request_out,
  input wire logic per_rd,
  input wire logic [7:0] base,
  input wire logic [15:0] lim,
  input wire logic [7:0] ack_dly,
  output logic bus_grant_acknowledge,
  output logic ext_req,
  output logic [7:0] per_data,
  output logic [15:0] given
);
  logic [7:0] ack_cnt;
  logic [3:0] gap;
  // Grant follows the request after ack_dly + 1 cycles and falls one cycle after it
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !bus_request_out)
    begin
      ack_cnt <= 8'h00;
      bus_grant_acknowledge <= 1'b0;
    end
    else
    begin
      if (ack_cnt < ack_dly)
        ack_cnt <= ack_cnt + 8'h01;
      bus_grant_acknowledge <= (ack_cnt >= ack_dly);
    end
  end
  // Short request per byte, spaced so a stale synchronised request cannot take a byte twice
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      given <= 16'h0000;
      gap <= 4'h0;
      ext_req <= 1'b0;
    end
    else
    begin
      gap <= per_rd ? 4'h0 : gap + 4'h1;
      if (per_rd)
        given <= given + 16'h0001;
      ext_req <= (gap == 4'hf) && (given < lim) && !per_rd;
    end
  end
  // No byte on offer: the lines show the inverse, never a stale valid byte
  assign per_data = (given < lim) ? base + given[7:0] : ~(base + given[7:0]);
endmodule

// ### dv/dbpp_channel_bench.sv
// Testbench for the byte-port packing channel: register tasks and a memory write scoreboard.
// Assumes dbpp_far_side stands in for the arbiter and the peripheral.
`timescale 1ns/1ps
module dbpp_channel_bench
  import dbpp_pkg::*;
;
  logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cpu_cs = 1'b0;
  logic peripheral_control_line = 1'b0, req_q = 1'b0, ack_seen = 1'b0, cs_seen = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, mem_addr, d;
  logic [15:0] mem_wdata, lim = 16'h0000, given, msk;
  logic [1:0] mem_be;
  logic [7:0] per_data, base = 8'h00, ack_dly = 8'h02;
  logic ext_req, bus_grant_acknowledge, bus_request_out, per_rd, mem_we, irq;
  logic [49:0] exp_q[$];
  int error_cnt = 0, num_checks = 0;

  dbpp_channel dut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_cs, .ext_req, .peripheral_control_line, .bus_grant_acknowledge, .bus_request_out,
    .per_rd, .per_data, .mem_we, .mem_addr, .mem_wdata, .mem_be, .irq);
  dbpp_far_side far (.clk_sys, .sys_rst, .bus_request_out, .per_rd, .base, .lim, .ack_dly,
    .bus_grant_acknowledge, .ext_req, .per_data, .given);

  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [31:0] f(input int p);
    return 32'h0000_0001 << p;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  always @(negedge clk_sys)
  begin
    if (!sys_rst && mem_we)
    begin
      if (exp_q.size() == 0)
        check(1, 0);
      else
        check({mem_addr, mem_be, mem_wdata & msk}, exp_q.pop_front());
    end
    if (req_q && !bus_request_out)
      check(ack_seen | cs_seen, 1);
    ack_seen = bus_request_out & (ack_seen | bus_grant_acknowledge);
    cs_seen = bus_request_out & (cs_seen | cpu_cs);
    req_q = bus_request_out;
  end

  // ab: 0 runs to the end, 1 software abort, 2 abort on the control line, 3 chip select then software abort
  task automatic run(input logic [31:0] c, input logic [1:0] sz, input int n, nb, ab,
                     input logic [31:0] ev, st);
    logic [31:0] a, ctl;
    logic pk;
    logic [7:0] bs;
    logic [15:0] g;
    int t;
    a = $urandom & 32'h0fff_fff0;
    bs = 8'($urandom);
    g = given;
    base <= bs;
    lim <= 16'(g + nb);
    ack_dly <= (ab == 3) ? 8'hc8 : 8'h02;
    ctl = c | f(DBPP_CTRL_P2M) | f(DBPP_CTRL_EXTREQ) | f(DBPP_CTRL_PORT8);
    ctl = ctl | (32'(sz) << DBPP_CTRL_SIZE_LO);
    pk = c[DBPP_CTRL_DUAL] && sz == DBPP_SIZE_WORD;
    msk = pk ? 16'hffff : 16'h00ff;
    for (int i = 0; i < (pk ? nb / 2 : nb); i++)
      exp_q.push_back(pk ? {a + 32'(2 * i), 2'b11, bs + 8'(g + 2 * i), bs + 8'(g + 2 * i + 1)}
                         : {a + 32'(i), 2'b01, 8'h00, bs + 8'(g + i)});
    wr(DBPP_OFS_IRQ_EN, sz == DBPP_SIZE_BPB ? DBPP_ZERO32 : 32'h0000_0007);
    wr(DBPP_OFS_ADDR, a);
    wr(DBPP_OFS_COUNT, 32'(n));
    wr(DBPP_OFS_CTRL, ctl | f(DBPP_CTRL_START));
    if (ab == 3)
    begin
      for (t = 0; t < 50 && !bus_request_out; t++) @(negedge clk_sys);
      @(posedge clk_sys);
      cpu_cs <= 1'b1;
      for (t = 0; t < 10 && bus_request_out; t++) @(negedge clk_sys);
      check(bus_request_out, 0);
      @(posedge clk_sys);
      ack_dly <= 8'h02;
      cpu_cs <= 1'b0;
    end
    if (ab != 0)
    begin
      for (t = 0; t < 800 && given != lim; t++) @(negedge clk_sys);
      repeat (40) @(posedge clk_sys);
      if (ab == 2)
        peripheral_control_line <= 1'b1;
      else
        wr(DBPP_OFS_CTRL, ctl | f(DBPP_CTRL_SAB));
    end
    d = DBPP_ZERO32;
    for (t = 0; t < 500 && d == DBPP_ZERO32; t++) rd(DBPP_OFS_IRQ_STAT);
    check(d, ev);
    check(irq, sz != DBPP_SIZE_BPB);
    rd(DBPP_OFS_STATUS);
    check(d, st);
    wr(DBPP_OFS_IRQ_CLR, 32'h0000_0007);
    wr(DBPP_OFS_CTRL, DBPP_ZERO32);
    peripheral_control_line <= 1'b0;
    rd(DBPP_OFS_IRQ_STAT);
    check({irq, d}, 0);
    check(exp_q.size(), 0);
    $display("test done ctl %h count %0d", ctl, n);
  endtask

  initial
  begin
    int n;
    void'($urandom(32'h264b));
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int a = 0; a < 16; a++)
    begin
      rd(4'(a));
      check(d, 0);
    end
    repeat (2)
    begin
      n = $urandom_range(4, 1);
      run(f(DBPP_CTRL_DUAL) | f(DBPP_CTRL_BURST), DBPP_SIZE_WORD, n, 2 * n, 0, 1, 0);
      run(f(DBPP_CTRL_DUAL), DBPP_SIZE_BPB, n, n, 0, 1, 0);
      run(0, DBPP_SIZE_BYTE, n, n, 0, 1, 0);
    end
    run(f(DBPP_CTRL_ABTMODE), DBPP_SIZE_BYTE, 3, 1, 2, 2, 0);
    run(0, DBPP_SIZE_BYTE, 1, 0, 3, 2, 0);
    run(f(DBPP_CTRL_DUAL), DBPP_SIZE_WORD, 2, 1, 1, 2, 4);
    finish_test();
  end

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    finish_test();
  end
endmodule
